// ==== shared/ddr2_pin_pkg.sv ====
// shared constants and types for the ddr2 command pin link
package ddr2_pin_pkg;
  localparam int NUM_GROUPS   = 2;   // two independent halves
  localparam int GROUP_W      = 32;  // data bits per half
  localparam int DQ_W         = 64;
  localparam int ADDR_W       = 13;
  localparam int BANK_W       = 2;
  localparam int NUM_BANKS    = 4;
  localparam int NUM_MODES    = 4;   // main plus three extended
  localparam int DIES         = 4;
  localparam int BYTES        = 4;   // byte lanes per half
  localparam int MEM_AW       = 6;   // bank, burst slot, beat
  localparam int AP_BIT       = 10;  // auto / all-bank precharge
  localparam int COL_LO       = 2;   // column bits that pick a slot
  localparam int MODE_EXT1    = 1;   // extended mode register one
  localparam int DIFF_OFF_BIT = 10;  // set: complement strobe off
  localparam int ODT_BIT_LO   = 2;   // either set: termination on
  localparam int ODT_BIT_HI   = 6;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  // host makes the link clock by dividing its own clock
  localparam int CLK_PERIOD_NS  = 4;
  localparam int LINK_PERIOD_NS = 16;
  localparam int LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_LAST = 2'(LINK_DIV - 1);
  // host operation timeline, in host cycles after the launch edge
  localparam logic [4:0] T_WR_FIRST = 5'h02;
  localparam logic [4:0] T_CMD_CLR  = 5'h03;
  localparam logic [4:0] T_RD_FIRST = 5'h08;
  localparam logic [4:0] T_WR_END   = 5'h0A;
  localparam logic [4:0] T_RD_LAST  = 5'h0E;
  localparam logic [4:0] T_OP_END   = 5'h0F;
  localparam logic [3:0] WR_BEAT0   = 4'h1;  // t/2 of first write beat
  localparam logic [3:0] RD_BEAT0   = 4'h4;  // t/2 of first read beat
  // {row, column, write} strobe levels
  typedef enum logic [2:0] {
    CMD_LOAD_MODE  = 3'h0,
    CMD_REFRESH    = 3'h1,
    CMD_PRECHARGE  = 3'h2,
    CMD_ACTIVATE   = 3'h3,
    CMD_WRITE      = 3'h4,
    CMD_READ       = 3'h5,
    CMD_BURST_STOP = 3'h6,
    CMD_NOP        = 3'h7
  } cmd_t;
  typedef enum logic [3:0] {
    PWR_ACTIVE   = 4'h1,
    PWR_PRE_PD   = 4'h2,
    PWR_ACT_PD   = 4'h4,
    PWR_SELF_REF = 4'h8
  } pwr_t;
endpackage

// ==== shared/ddr2_pin_if.sv ====
// pin bundle between the memory end and the controller end
`timescale 1ns/1ns
`default_nettype none
interface ddr2_pin_if;
  import ddr2_pin_pkg::*;
  logic                link_clk;
  logic                clock_enable_group_a;
  logic                clock_enable_group_b;
  logic                chip_select_group_a_n;
  logic                chip_select_group_b_n;
  logic [1:0]          row_strobe_n;      // index 0 is group a
  logic [1:0]          col_strobe_n;
  logic [1:0]          write_enable_n;
  logic [BANK_W-1:0]   bank;
  logic [ADDR_W-1:0]   addr;
  logic                odt;
  logic [DIES-1:0]     lower_byte_write_mask;
  logic [DIES-1:0]     upper_byte_write_mask;
  // per-end drivers of the two-way pins
  logic [DQ_W-1:0]     host_dq;
  logic [1:0]          host_dq_oe;
  logic [DIES-1:0]     host_stb;
  logic [DIES-1:0]     host_stb_n;
  logic [1:0]          host_stb_oe;
  logic [DQ_W-1:0]     mem_dq;
  logic [1:0]          mem_dq_oe;
  logic [DIES-1:0]     mem_stb;
  logic [DIES-1:0]     mem_stb_n;
  logic [1:0]          mem_stb_oe;
  logic [1:0]          mem_stb_n_oe;
  // resolved wire levels, low when nobody drives
  logic [DQ_W-1:0]     dq;
  logic [DIES-1:0]     lower_byte_strobe;
  logic [DIES-1:0]     upper_byte_strobe;
  logic [DIES-1:0]     lower_byte_strobe_n;
  logic [DIES-1:0]     upper_byte_strobe_n;

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : res_g
    assign dq[g*GROUP_W +: GROUP_W] = host_dq_oe[g] ? host_dq[g*GROUP_W +: GROUP_W] :
                                      mem_dq_oe[g] ? mem_dq[g*GROUP_W +: GROUP_W] : 32'h0;
  end
  for (genvar d = 0; d < DIES; d++) begin : res_d
    assign lower_byte_strobe[d]   = host_stb_oe[d/2] ? host_stb[d] :
                                    mem_stb_oe[d/2] & mem_stb[d];
    assign upper_byte_strobe[d]   = lower_byte_strobe[d];
    assign lower_byte_strobe_n[d] = host_stb_oe[d/2] ? host_stb_n[d] :
                                    mem_stb_n_oe[d/2] & mem_stb_n[d];
    assign upper_byte_strobe_n[d] = lower_byte_strobe_n[d];
  end

  modport memory (
    input  link_clk, clock_enable_group_a, clock_enable_group_b,
    input  chip_select_group_a_n, chip_select_group_b_n,
    input  row_strobe_n, col_strobe_n, write_enable_n, bank, addr, odt,
    input  lower_byte_write_mask, upper_byte_write_mask, dq,
    input  lower_byte_strobe, upper_byte_strobe,
    input  lower_byte_strobe_n, upper_byte_strobe_n,
    output mem_dq, mem_dq_oe, mem_stb, mem_stb_n, mem_stb_oe, mem_stb_n_oe
  );
  modport controller (
    output link_clk, clock_enable_group_a, clock_enable_group_b,
    output chip_select_group_a_n, chip_select_group_b_n,
    output row_strobe_n, col_strobe_n, write_enable_n, bank, addr, odt,
    output lower_byte_write_mask, upper_byte_write_mask,
    output host_dq, host_dq_oe, host_stb, host_stb_n, host_stb_oe,
    input  dq, lower_byte_strobe, upper_byte_strobe,
    input  lower_byte_strobe_n, upper_byte_strobe_n
  );
endinterface
`default_nettype wire

// ==== core/ddr2_memory_end.sv ====
// memory end of the ddr2 pin link: command decode, power states, burst data
//
// Notes on behaviour
// - registered clock enable switches internal clocking
// - enable low: precharge/self refresh or active power-down
// - clock enable sampled on clock for entries
// - self refresh exit seen without a clock
// - power-down: only enable and termination inputs live
// - self refresh: only clock enable input live
// - chip select high masks every command
// - command from strobes plus select, same cycle
// - masked write beats are not stored
// - mask sampled each strobe edge, one per beat
// - lower mask bytes 0-7, upper 8-15
// - bank bits pick bank for bank commands
// - bank bits pick mode register on load
// - address: row, column, bit 10 auto precharge
// - precharge bit 10 low one bank, high all
// - load mode writes address as op code
// - read strobe edge-aligned, write strobe centred
// - complement strobe only in differential mode
// - 64-bit data bus, two-way
// - command inputs registered on rising link clock, write data and mask on both edges
// - termination input ignored when disabled
`timescale 1ns/1ns
`default_nettype none
module ddr2_memory_end
  import ddr2_pin_pkg::*;
(
  input  wire logic                       rst_i,           // async reset, high
  ddr2_pin_if.memory                      pins,            // link pins
  output logic [NUM_GROUPS-1:0][3:0]      power_state_o,   // pwr_t per half
  output logic [NUM_GROUPS-1:0]           clocking_on_o,   // internal clocking
  output logic [NUM_GROUPS-1:0][NUM_BANKS-1:0] open_banks_o, // rows open
  output logic [NUM_GROUPS-1:0]           term_active_o,   // termination on
  output logic [NUM_GROUPS-1:0]           diff_strobe_o    // complement used
);
  logic [1:0]            rst_sync_q;
  logic                  rst_l;
  logic [1:0]            cke;
  logic [1:0]            cs_n;

  // reset release retimed to the link clock
  always_ff @(posedge pins.link_clk or posedge rst_i) begin
    if (rst_i) begin
      rst_sync_q <= 2'h3;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b0};
    end
  end
  assign rst_l = rst_sync_q[1];

  // per-half controls, the halves never interact
  assign cke  = {pins.clock_enable_group_b, pins.clock_enable_group_a};
  assign cs_n = {pins.chip_select_group_b_n, pins.chip_select_group_a_n};

  // byte-masked merge of a write beat into a stored word
  function automatic logic [GROUP_W-1:0] merge(input logic [GROUP_W-1:0] old_w,
                                               input logic [GROUP_W-1:0] new_w,
                                               input logic [BYTES-1:0]   mask);
    logic [GROUP_W-1:0] res;
    res = old_w;
    for (int b = 0; b < BYTES; b++) begin
      if (!mask[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : grp
    logic                 cke_q;
    logic                 sr_q;
    logic                 odt_q;
    pwr_t                 pwr_q;
    logic [NUM_BANKS-1:0] open_q;
    logic [ADDR_W-1:0]    mode_q [NUM_MODES];
    logic [GROUP_W-1:0]   mem [2**MEM_AW];
    logic [1:0]           wr_cnt_q;
    logic [1:0]           rd_cnt_q;
    logic [3:0]           wr_base_q;
    logic [3:0]           rd_base_q;
    logic                 rd_oe_q;
    logic [GROUP_W-1:0]   pos_q;
    logic [GROUP_W-1:0]   neg_q;
    logic [GROUP_W-1:0]   cap_q;
    logic [BYTES-1:0]     cap_mask_q;
    cmd_t                 cmd;
    logic                 cmd_ok;
    logic                 sr_entry;
    logic                 sr_wake;
    logic                 odt_en;
    logic                 diff_en;
    logic [BYTES-1:0]     mask_now;
    logic [GROUP_W-1:0]   dq_now;

    // decode only when selected, awake and powered up
    assign cmd    = cmd_t'({pins.row_strobe_n[g], pins.col_strobe_n[g],
                            pins.write_enable_n[g]});
    assign cmd_ok = ~cs_n[g] & cke_q & cke[g] & ~sr_q
                    & (pwr_q == PWR_ACTIVE);
    assign sr_entry = ~cs_n[g] & cke_q & ~cke[g] & (cmd == CMD_REFRESH)
                      & (open_q == 4'h0) & (pwr_q == PWR_ACTIVE) & ~sr_q;
    assign sr_wake  = rst_l | cke[g];
    assign odt_en   = mode_q[MODE_EXT1][ODT_BIT_LO] | mode_q[MODE_EXT1][ODT_BIT_HI];
    assign diff_en  = ~mode_q[MODE_EXT1][DIFF_OFF_BIT];
    // lanes: die 2g lower, upper, then die 2g+1 lower, upper
    assign mask_now = {pins.upper_byte_write_mask[2*g+1], pins.lower_byte_write_mask[2*g+1],
                       pins.upper_byte_write_mask[2*g], pins.lower_byte_write_mask[2*g]};
    assign dq_now   = pins.dq[g*GROUP_W +: GROUP_W];

    // registered clock enable drives the clocking state
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        cke_q <= 1'b0;
      end else begin
        cke_q <= cke[g];
      end
    end

    // self refresh clears on a rising enable level, no clock needed,
    // because the link clock may be stopped while refreshing
    always_ff @(posedge pins.link_clk or posedge sr_wake) begin
      if (sr_wake) begin
        sr_q <= 1'b0;
      end else if (sr_entry) begin
        sr_q <= 1'b1;
      end
    end

    // power-down entry on registered enable, exit on the live enable
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        pwr_q <= PWR_ACTIVE;
      end else begin
        case (pwr_q)
          PWR_ACTIVE: begin
            if (cke_q && !cke[g] && !sr_entry && !sr_q) begin
              pwr_q <= (open_q != 4'h0) ? PWR_ACT_PD : PWR_PRE_PD;
            end
          end
          PWR_PRE_PD, PWR_ACT_PD: begin
            if (cke[g]) begin
              pwr_q <= PWR_ACTIVE;
            end
          end
          default: pwr_q <= PWR_ACTIVE;
        endcase
      end
    end

    // open-row bookkeeping; auto precharge closes at command time
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        open_q <= 4'h0;
      end else if (cmd_ok) begin
        case (cmd)
          CMD_ACTIVATE:  open_q[pins.bank] <= 1'b1;
          CMD_PRECHARGE: begin
            if (pins.addr[AP_BIT]) begin
              open_q <= 4'h0;
            end else begin
              open_q[pins.bank] <= 1'b0;
            end
          end
          CMD_READ, CMD_WRITE: begin
            if (pins.addr[AP_BIT]) begin
              open_q[pins.bank] <= 1'b0;
            end
          end
          default: open_q <= open_q;
        endcase
      end
    end

    // mode registers written by load mode
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        for (int m = 0; m < NUM_MODES; m++) begin
          mode_q[m] <= MODE_RESET;
        end
      end else if (cmd_ok && cmd == CMD_LOAD_MODE) begin
        mode_q[pins.bank] <= pins.addr;
      end
    end

    // termination follows its input only when enabled and awake
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        odt_q <= 1'b0;
      end else begin
        odt_q <= pins.odt & odt_en & ~sr_q;
      end
    end

    // burst sequencing: two link cycles of two beats each
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        wr_cnt_q  <= 2'h0;
        rd_cnt_q  <= 2'h0;
        wr_base_q <= 4'h0;
        rd_base_q <= 4'h0;
      end else begin
        wr_cnt_q <= (wr_cnt_q != 2'h0) ? 2'(wr_cnt_q - 2'h1) : 2'h0;
        rd_cnt_q <= (rd_cnt_q != 2'h0) ? 2'(rd_cnt_q - 2'h1) : 2'h0;
        if (cmd_ok && cmd == CMD_WRITE) begin
          wr_cnt_q  <= 2'h2;
          wr_base_q <= {pins.bank, pins.addr[COL_LO +: 2]};
        end
        if (cmd_ok && cmd == CMD_READ) begin
          rd_cnt_q  <= 2'h2;
          rd_base_q <= {pins.bank, pins.addr[COL_LO +: 2]};
        end
      end
    end

    // falling-edge half: capture even write beats, launch odd read beats
    always_ff @(negedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        cap_q      <= 32'h0;
        cap_mask_q <= 4'hF;
        neg_q      <= 32'h0;
      end else begin
        cap_q      <= dq_now;
        cap_mask_q <= mask_now;
        if (rd_oe_q) begin
          neg_q <= mem[{rd_base_q, ~rd_cnt_q[0], 1'b1}];
        end
      end
    end

    // rising edge stores the captured beat and the live beat
    always_ff @(posedge pins.link_clk) begin
      if (wr_cnt_q != 2'h0) begin
        mem[{wr_base_q, wr_cnt_q[0], 1'b0}] <=
          merge(mem[{wr_base_q, wr_cnt_q[0], 1'b0}], cap_q, cap_mask_q);
        mem[{wr_base_q, wr_cnt_q[0], 1'b1}] <=
          merge(mem[{wr_base_q, wr_cnt_q[0], 1'b1}], dq_now, mask_now);
      end
    end

    // rising-edge half of read: even beats and the drive window
    always_ff @(posedge pins.link_clk or posedge rst_l) begin
      if (rst_l) begin
        pos_q   <= 32'h0;
        rd_oe_q <= 1'b0;
      end else begin
        if (rd_cnt_q != 2'h0) begin
          pos_q <= mem[{rd_base_q, rd_cnt_q[0], 1'b0}];
        end
        if (rd_cnt_q == 2'h2) begin
          rd_oe_q <= 1'b1;
        end else if (rd_cnt_q == 2'h0) begin
          rd_oe_q <= 1'b0;
        end
      end
    end

    // read data and strobe both change on link edges
    assign pins.mem_dq[g*GROUP_W +: GROUP_W] = pins.link_clk ? pos_q : neg_q;
    assign pins.mem_dq_oe[g]    = rd_oe_q;
    assign pins.mem_stb[2*g +: 2]   = {2{pins.link_clk}};
    assign pins.mem_stb_n[2*g +: 2] = {2{~pins.link_clk}};
    assign pins.mem_stb_oe[g]   = rd_oe_q;
    assign pins.mem_stb_n_oe[g] = rd_oe_q & diff_en;

    assign power_state_o[g] = sr_q ? PWR_SELF_REF : pwr_q;
    assign clocking_on_o[g] = cke_q & ~sr_q;
    assign open_banks_o[g]  = open_q;
    assign term_active_o[g] = odt_q;
    assign diff_strobe_o[g] = diff_en;
  end
endmodule
`default_nettype wire

// ==== core/ddr2_host_end.sv ====
// controller end of the ddr2 pin link: makes link clock, issues commands
`timescale 1ns/1ns
`default_nettype none
module ddr2_host_end
  import ddr2_pin_pkg::*;
(
  input  wire logic                clk_i,         // 250 MHz
  input  wire logic                rst_i,         // async reset, high
  ddr2_pin_if.controller           pins,          // link pins
  input  wire logic                req_valid_i,   // command request
  output logic                     req_ready_o,   // request taken this edge
  input  wire cmd_t                req_cmd_i,     // command code
  input  wire logic                req_group_i,   // 0 half a, 1 half b
  input  wire logic [BANK_W-1:0]   req_bank_i,    // bank or mode select
  input  wire logic [ADDR_W-1:0]   req_addr_i,    // row, column or op code
  input  wire logic [4*GROUP_W-1:0] req_wdata_i,  // four beats, beat 0 low
  input  wire logic [4*BYTES-1:0]  req_wmask_i,   // byte masks, beat 0 low
  input  wire logic [1:0]          cke_i,         // wanted enable per half
  input  wire logic                odt_i,         // wanted termination
  output logic [4*GROUP_W-1:0]     rd_data_o,     // four read beats
  output logic                     rd_valid_o     // one-cycle pulse
);
  logic [1:0]          div_q;
  logic                busy_q;
  logic [4:0]          t_q;
  cmd_t                op_q;
  logic                grp_q;
  logic [4*GROUP_W-1:0] wdata_q;
  logic [4*BYTES-1:0]  wmask_q;
  logic [1:0]          wbeat;
  logic [1:0]          rbeat;
  logic [BYTES-1:0]    mask_nib;
  logic [DQ_W-1:0]     dq_s1_q;
  logic [DQ_W-1:0]     dq_s2_q;
  logic [GROUP_W-1:0]  wbeat_q;
  logic                take;

  // link clock is the divided host clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= 2'(div_q + 2'h1);
    end
  end
  assign pins.link_clk = div_q[1];

  // launch just before a falling link edge, so pins settle for the rise
  assign req_ready_o = ~busy_q & (div_q == DIV_LAST);
  assign take        = req_valid_i & req_ready_o;
  assign wbeat = 2'(t_q[4:1] - WR_BEAT0);
  assign rbeat = 2'(t_q[4:1] - RD_BEAT0);

  // operation timeline
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q  <= 1'b0;
      t_q     <= 5'h00;
      op_q    <= CMD_NOP;
      grp_q   <= 1'b0;
      wdata_q <= 128'h0;
      wmask_q <= 16'hFFFF;
    end else if (take) begin
      busy_q  <= 1'b1;
      t_q     <= 5'h00;
      op_q    <= req_cmd_i;
      grp_q   <= req_group_i;
      wdata_q <= req_wdata_i;
      wmask_q <= req_wmask_i;
    end else if (busy_q) begin
      t_q <= 5'(t_q + 5'h01);
      if (t_q == T_OP_END) begin
        busy_q <= 1'b0;
      end
    end
  end

  // command pins: select and strobes one link cycle wide, bank and address held to the next request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins.chip_select_group_a_n <= 1'b1;
      pins.chip_select_group_b_n <= 1'b1;
      pins.row_strobe_n   <= 2'h3;
      pins.col_strobe_n   <= 2'h3;
      pins.write_enable_n <= 2'h3;
      pins.bank <= 2'h0;
      pins.addr <= 13'h0000;
    end else if (take) begin
      pins.chip_select_group_a_n <= req_group_i;
      pins.chip_select_group_b_n <= ~req_group_i;
      pins.row_strobe_n   <= {2{req_cmd_i[2]}};
      pins.col_strobe_n   <= {2{req_cmd_i[1]}};
      pins.write_enable_n <= {2{req_cmd_i[0]}};
      pins.bank <= req_bank_i;
      pins.addr <= req_addr_i;
    end else if (busy_q && t_q == T_CMD_CLR) begin
      pins.chip_select_group_a_n <= 1'b1;
      pins.chip_select_group_b_n <= 1'b1;
      pins.row_strobe_n   <= 2'h3;
      pins.col_strobe_n   <= 2'h3;
      pins.write_enable_n <= 2'h3;
    end
  end

  // enable and termination change only at the launch phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins.clock_enable_group_a <= 1'b0;
      pins.clock_enable_group_b <= 1'b0;
      pins.odt <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      pins.clock_enable_group_a <= cke_i[0];
      pins.clock_enable_group_b <= cke_i[1];
      pins.odt <= odt_i;
    end
  end

  // write beats change mid-way between link edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wbeat_q         <= 32'h0;
      mask_nib        <= 4'hF;
      pins.host_dq_oe <= 2'h0;
    end else if (busy_q && op_q == CMD_WRITE) begin
      if (t_q >= T_WR_FIRST && t_q < T_WR_END && !t_q[0]) begin
        wbeat_q  <= wdata_q[wbeat*GROUP_W +: GROUP_W];
        mask_nib <= wmask_q[wbeat*BYTES +: BYTES];
        pins.host_dq_oe[grp_q] <= 1'b1;
      end else if (t_q == T_WR_END) begin
        pins.host_dq_oe <= 2'h0;
      end
    end
  end
  assign pins.host_dq               = {2{wbeat_q}};
  assign pins.lower_byte_write_mask = {2{mask_nib[2], mask_nib[0]}};
  assign pins.upper_byte_write_mask = {2{mask_nib[3], mask_nib[1]}};
  // strobe follows the link clock, so edges land mid-beat
  assign pins.host_stb    = {DIES{div_q[1]}};
  assign pins.host_stb_n  = {DIES{~div_q[1]}};
  assign pins.host_stb_oe = pins.host_dq_oe;

  // read data passes two flops before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_s1_q <= 64'h0;
      dq_s2_q <= 64'h0;
    end else begin
      dq_s1_q <= pins.dq;
      dq_s2_q <= dq_s1_q;
    end
  end

  // pick each read beat at its mid-point, delayed by the synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o  <= 128'h0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= busy_q & (op_q == CMD_READ) & (t_q == T_RD_LAST);
      if (busy_q && op_q == CMD_READ && t_q >= T_RD_FIRST
          && t_q <= T_RD_LAST && !t_q[0]) begin
        rd_data_o[rbeat*GROUP_W +: GROUP_W] <= dq_s2_q[grp_q*GROUP_W +: GROUP_W];
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ddr2_pin_sva.sv ====
// assertions on the ddr2 link pins
`timescale 1ns/1ns
`default_nettype none
module ddr2_pin_sva (
  input wire logic       clk_i,                 // host clock
  input wire logic       rst_i,                 // reset
  input wire logic       link_clk,              // link clock
  input wire logic       clock_enable_group_a,  // enable a
  input wire logic       chip_select_group_a_n, // select a
  input wire logic       chip_select_group_b_n, // select b
  input wire logic [1:0] row_strobe_n,          // row strobes
  input wire logic [1:0] col_strobe_n,          // column strobes
  input wire logic [1:0] write_enable_n,        // write strobes
  input wire logic [1:0] host_dq_oe,            // host drive
  input wire logic [1:0] mem_dq_oe,             // memory drive
  input wire logic [1:0] mem_stb_oe,            // memory strobe drive
  input wire logic [3:0] lower_byte_strobe      // wire strobe
);
  // host side: command held long enough for one link rise
  a_no_contention: assert property (
    @(posedge clk_i) disable iff (rst_i) !(host_dq_oe[0] && mem_dq_oe[0])) else $error("clash");
  a_cmd_hold: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(chip_select_group_a_n)
    |-> !chip_select_group_a_n [*4] ##1 chip_select_group_a_n) else $error("select span");
  a_write_cause: assert property (
    @(posedge clk_i) disable iff (rst_i) $rose(host_dq_oe[0]) |-> $past(!chip_select_group_a_n
    && row_strobe_n[0] && !col_strobe_n[0] && !write_enable_n[0])) else $error("stray write");
  a_write_span: assert property (
    @(posedge clk_i) disable iff (rst_i) $rose(host_dq_oe[0])
    |-> host_dq_oe[0] [*8] ##1 !host_dq_oe[0]) else $error("write span");
  a_read_strobe: assert property (
    @(posedge clk_i) disable iff (rst_i) mem_stb_oe[0]
    |-> lower_byte_strobe[0] == link_clk) else $error("read strobe");
  // link side: a drive needs a selected read with the enable held
  a_read_cause: assert property (
    @(posedge link_clk) disable iff (rst_i) $rose(mem_dq_oe[0]) |-> $past(!chip_select_group_a_n
    && row_strobe_n[0] && !col_strobe_n[0] && write_enable_n[0], 2)) else $error("stray read");
  a_pd_quiet: assert property (
    @(posedge link_clk) disable iff (rst_i)
    !clock_enable_group_a [*4] |-> !mem_dq_oe[0]) else $error("drive in power-down");
  a_idle_half_b: assert property (
    @(posedge link_clk) disable iff (rst_i)
    chip_select_group_b_n [*4] |-> !mem_dq_oe[1]) else $error("half b drive");
endmodule
`default_nettype wire

// ==== testbench/ddr2_pin_command_interface_tb.sv ====
// self-checking bench joining host end and memory end
`timescale 1ns/1ns
`default_nettype none
module ddr2_pin_command_interface_tb;
  import ddr2_pin_pkg::*;
  logic            clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_group_i = 1'b0;
  logic            odt_i = 1'b1, req_ready_o, rd_valid_o;
  cmd_t            req_cmd_i = CMD_NOP;
  logic [1:0]      req_bank_i = 2'h0, cke_i = 2'h3, clocking_on_o, term_active_o, diff_strobe_o;
  logic [1:0]      bk [2];
  logic [12:0]     req_addr_i = 13'h0000;
  logic [15:0]     req_wmask_i = 16'h0000;
  logic [127:0]    req_wdata_i = 128'h0, rd_data_o, rd, sv, mdl [2][4];
  logic [1:0][3:0] power_state_o, open_banks_o;
  int              n_mismatch = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  ddr2_pin_if pins ();
  ddr2_host_end ddr2_host_end_inst (.clk_i, .rst_i, .pins, .req_valid_i, .req_ready_o,
    .req_cmd_i, .req_group_i, .req_bank_i, .req_addr_i, .req_wdata_i, .req_wmask_i,
    .cke_i, .odt_i, .rd_data_o, .rd_valid_o);
  ddr2_memory_end ddr2_memory_end_inst (.rst_i, .pins, .power_state_o, .clocking_on_o,
    .open_banks_o, .term_active_o, .diff_strobe_o);
  ddr2_pin_sva ddr2_pin_sva_inst (.clk_i, .rst_i, .link_clk(pins.link_clk),
    .clock_enable_group_a(pins.clock_enable_group_a), .mem_stb_oe(pins.mem_stb_oe),
    .chip_select_group_a_n(pins.chip_select_group_a_n), .host_dq_oe(pins.host_dq_oe),
    .chip_select_group_b_n(pins.chip_select_group_b_n), .mem_dq_oe(pins.mem_dq_oe),
    .row_strobe_n(pins.row_strobe_n), .col_strobe_n(pins.col_strobe_n),
    .write_enable_n(pins.write_enable_n), .lower_byte_strobe(pins.lower_byte_strobe));
  task chk(input string nm, input logic [127:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, then the full spacing; a read pulse is caught on the way
  task req(input cmd_t c, input logic g, input logic [1:0] b, input logic [12:0] a);
    int n;
    n = 0;
    rd = 'x;
    req_cmd_i = c;
    {req_group_i, req_bank_i, req_addr_i, req_valid_i} = {g, b, a, 1'b1};
    do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 40);
    #1 req_valid_i = 1'b0;
    if (n >= 40) n_mismatch++;
    repeat (20) begin
      @(posedge clk_i);
      if (rd_valid_o === 1'b1) rd = rd_data_o;
    end
    #1;
  endtask
  task wr(input logic g, input logic [1:0] b, input logic [15:0] m);
    req_wdata_i = {$urandom, $urandom, $urandom, $urandom};
    req_wmask_i = m;
    for (int i = 0; i < 16; i++)
      if (!m[i]) mdl[g][b][8*i +: 8] = req_wdata_i[8*i +: 8];
    req(CMD_WRITE, g, b, 13'h0004);
  endtask
  task rdc(input logic g, input logic [1:0] b);
    req(CMD_READ, g, b, 13'h0004);
    chk("rdata", rd, mdl[g][b]);
  endtask
  task end_sim;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #100000 n_mismatch++;
    end_sim();
  end
  initial begin
    void'($urandom(66));
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (12) @(posedge clk_i);
    #1 req(CMD_LOAD_MODE, 1'b0, 2'(MODE_EXT1), 13'h0404);
    req(CMD_LOAD_MODE, 1'b0, 2'h0, 13'h0000);
    chk("mode", {term_active_o, diff_strobe_o}, 4'h6);
    for (int g = 0; g < 2; g++) begin
      bk[g] = 2'($urandom);
      req(CMD_ACTIVATE, g[0], bk[g], 13'($urandom));
    end
    chk("open", open_banks_o, {4'h1 << bk[1], 4'h1 << bk[0]});
    for (int g = 0; g < 2; g++) begin
      wr(g[0], bk[g], 16'h0000);
      wr(g[0], bk[g], 16'($urandom));
      rdc(g[0], bk[g]);
    end
    $display("data test done");
    cke_i = 2'h2;
    repeat (12) @(posedge clk_i);
    #1 chk("pd", {power_state_o[0], clocking_on_o}, {PWR_ACT_PD, 2'h2});
    sv = mdl[0][bk[0]];
    wr(1'b0, bk[0], 16'h0000);
    mdl[0][bk[0]] = sv;
    req(CMD_READ, 1'b0, bk[0], 13'h0004);
    chk("pd read", rd, 128'h0);
    cke_i = 2'h3;
    repeat (12) @(posedge clk_i);
    #1 rdc(1'b0, bk[0]);
    $display("power-down test done");
    req(CMD_ACTIVATE, 1'b0, bk[0] ^ 2'h1, 13'h0000);
    req(CMD_PRECHARGE, 1'b0, bk[0], 13'h0000);
    chk("one shut", open_banks_o, {4'h1 << bk[1], 4'h1 << (bk[0] ^ 2'h1)});
    req(CMD_PRECHARGE, 1'b1, bk[1] + 2'h1, 13'h0400);
    req(CMD_PRECHARGE, 1'b0, bk[0], 13'h0400);
    chk("all shut", open_banks_o, 8'h00);
    cke_i = 2'h1;
    repeat (12) @(posedge clk_i);
    #1 chk("idle pd", power_state_o[1], PWR_PRE_PD);
    cke_i = 2'h3;
    repeat (12) @(posedge clk_i);
    #1 cke_i = 2'h1;
    req(CMD_REFRESH, 1'b1, 2'h0, 13'h0000);
    chk("self ref", power_state_o[1], PWR_SELF_REF);
    cke_i = 2'h3;
    repeat (8) @(posedge clk_i);
    #1 chk("sr exit", power_state_o[1], PWR_ACTIVE);
    $display("bank test done");
    end_sim();
  end
endmodule
`default_nettype wire
